// *** rtl/spld_params.svh ***
/*
 Constants of the serial peripheral link device: software register offsets,
 status bit positions, reset values and link counts.
 Assumes inclusion by its bare name from the design file.
*/
`ifndef SPLD_PARAMS_SVH
`define SPLD_PARAMS_SVH

// ----------------------------------------------------------------------------
// Software register offsets
// ----------------------------------------------------------------------------
`define SPLD_CTRL_OFS 8'h00
`define SPLD_STATUS_OFS 8'h04
`define SPLD_MASK_OFS 8'h08
`define SPLD_LAST_CMD_OFS 8'h0C
`define SPLD_MAP_INDEX_OFS 8'h10
`define SPLD_MAP_DATA_OFS 8'h14
`define SPLD_LINK_STATE_OFS 8'h18

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define SPLD_CTRL_LINK_ON 0
`define SPLD_EV_WRITE 0
`define SPLD_EV_READ 1
`define SPLD_EV_RESYNC 2
`define SPLD_EV_ABORT 3
`define SPLD_CMD_WRITE_BIT 1

// ----------------------------------------------------------------------------
// Reset values and counts
// ----------------------------------------------------------------------------
`define SPLD_CTRL_RESET 1'h1
`define SPLD_MASK_RESET 4'h0
`define SPLD_ONES_LIMIT 5'h10
`define SPLD_LAST_BIT 3'h7
`define SPLD_MAP_DEPTH 64

`endif

// *** rtl/spld_pkg.sv ***
/*
 Types of the serial peripheral link device.
 Assumes nothing of its surroundings.
*/
package spld_pkg;

   typedef enum logic [1:0] {
      spld_idle = 2'b00,
      spld_cmd = 2'b01,
      spld_write = 2'b10,
      spld_read = 2'b11
   } spld_state_type;

endpackage : spld_pkg

// *** rtl/spld_device.sv ***
/*
 Peripheral end of a three-wire serial link: clock, shared data line and
 chip enable, with a 64 x 8 register map and a software register port.
 Assumes link pins are asynchronous to clock and the link clock is much
 slower than clock (several clock periods per link clock phase).
*/
// Decided for this implementation: the register addresses and the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none
`include "spld_params.svh"

module spld_device (
   input wire logic clock,
   input wire logic rst,
   input wire logic link_clock,
   input wire logic chip_enable,
   input wire logic serial_in,
   output logic serial_out,
   output logic serial_oe_n,
   output logic direction_flag_n,
   input wire logic [7:0] address,
   input wire logic [31:0] write_data,
   input wire logic write_strobe,
   input wire logic read_strobe,
   output logic [31:0] read_data,
   output logic irq
);
   import spld_pkg::*;

   // -------------------------------------------------------------------------
   // Pin synchronisers and edge detection
   // -------------------------------------------------------------------------
   logic [1:0] clk_sync;
   logic [1:0] ce_sync;
   logic [1:0] line_sync;
   logic clk_prev;
   logic link_on;

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         // The link clock idles high; a low reset value would fake a rise.
         clk_sync <= 2'h3;
         ce_sync <= 2'h0;
         line_sync <= 2'h3;
      end else begin
         clk_sync <= {clk_sync[0], link_clock};
         ce_sync <= {ce_sync[0], chip_enable};
         line_sync <= {line_sync[0], serial_in};
      end
   end

   wire logic enabled = ce_sync[1] & link_on;
   wire logic line_bit = line_sync[1];

   // While disabled the previous clock level keeps following the pin, so an
   // enable raised with the clock already high waits for a low then a rise.
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         clk_prev <= 1'h1;
      end else begin
         clk_prev <= clk_sync[1];
      end
   end

   wire logic rise = enabled & clk_sync[1] & ~clk_prev;
   wire logic fall = enabled & ~clk_sync[1] & clk_prev;

   // -------------------------------------------------------------------------
   // Link state machine
   // -------------------------------------------------------------------------
   spld_state_type state;
   logic [2:0] bit_count;
   logic [7:0] cmd_shift;
   logic [7:0] data_shift;
   logic [7:0] read_shift;
   logic [5:0] link_addr;
   logic [4:0] ones_count;
   logic [7:0] map [`SPLD_MAP_DEPTH];
   logic link_write;
   logic ev_write;
   logic ev_read;
   logic ev_resync;
   logic ev_abort;

   wire logic [7:0] next_cmd = {line_bit, cmd_shift[7:1]};
   wire logic [7:0] next_data = {line_bit, data_shift[7:1]};
   wire logic busy = (state != spld_idle);

   // Run of ones on the line seen at rising edges; ones are not counted while the
   // device itself drives, since then the line level is its own data, but zeros still clear the run.
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         ones_count <= 5'h0;
      end else if (!enabled || (rise && !line_bit)) begin
         ones_count <= 5'h0;
      end else if (rise && state != spld_read && ones_count != `SPLD_ONES_LIMIT) begin
         ones_count <= ones_count + 5'h1;
      end
   end

   wire logic ones_hit = rise && line_bit && state != spld_read &&
                         ones_count == (`SPLD_ONES_LIMIT - 5'h1);

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         state <= spld_idle;
         bit_count <= 3'h0;
         cmd_shift <= 8'hFF;
         data_shift <= 8'h00;
         read_shift <= 8'h00;
         link_addr <= 6'h00;
         link_write <= 1'h0;
         ev_write <= 1'h0;
         ev_read <= 1'h0;
         ev_resync <= 1'h0;
         ev_abort <= 1'h0;
      end else begin
         link_write <= 1'h0;
         ev_write <= 1'h0;
         ev_read <= 1'h0;
         ev_resync <= 1'h0;
         ev_abort <= 1'h0;
         if (!enabled) begin
            ev_abort <= busy;
            state <= spld_idle;
            bit_count <= 3'h0;
         end else if (ones_hit) begin
            ev_resync <= busy;
            state <= spld_idle;
            bit_count <= 3'h0;
         end else if (rise) begin
            case (state)
               spld_idle: begin
                  if (!line_bit) begin
                     cmd_shift <= next_cmd;
                     bit_count <= 3'h1;
                     state <= spld_cmd;
                  end
               end
               spld_cmd: begin
                  cmd_shift <= next_cmd;
                  bit_count <= bit_count + 3'h1;
                  if (bit_count == `SPLD_LAST_BIT) begin
                     link_addr <= next_cmd[7:2];
                     bit_count <= 3'h0;
                     if (next_cmd[`SPLD_CMD_WRITE_BIT]) begin
                        state <= spld_write;
                     end else begin
                        read_shift <= map[next_cmd[7:2]];
                        state <= spld_read;
                     end
                  end
               end
               spld_write: begin
                  data_shift <= next_data;
                  bit_count <= bit_count + 3'h1;
                  if (bit_count == `SPLD_LAST_BIT) begin
                     link_write <= 1'h1;
                     ev_write <= 1'h1;
                     state <= spld_idle;
                  end
               end
               spld_read: begin
                  read_shift <= {1'h0, read_shift[7:1]};
                  bit_count <= bit_count + 3'h1;
                  if (bit_count == `SPLD_LAST_BIT) begin
                     ev_read <= 1'h1;
                     state <= spld_idle;
                  end
               end
               default: begin
                  state <= spld_idle;
               end
            endcase
         end
      end
   end

   // -------------------------------------------------------------------------
   // Line driver: read data goes out on falling edges, least significant first
   // -------------------------------------------------------------------------
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         serial_out <= 1'h1;
         serial_oe_n <= 1'h1;
         direction_flag_n <= 1'h1;
      end else if (state != spld_read || !enabled || ones_hit) begin
         serial_out <= 1'h1;
         serial_oe_n <= 1'h1;
         direction_flag_n <= 1'h1;
      end else if (rise && bit_count == `SPLD_LAST_BIT) begin
         serial_out <= 1'h1;
         serial_oe_n <= 1'h1;
         direction_flag_n <= 1'h1;
      end else if (fall) begin
         serial_out <= read_shift[0];
         serial_oe_n <= 1'h0;
         direction_flag_n <= 1'h0;
      end
   end

   // -------------------------------------------------------------------------
   // Software registers
   // -------------------------------------------------------------------------
   logic [3:0] status;
   logic [3:0] mask;
   logic [5:0] map_index;
   logic [7:0] last_cmd;

   wire logic [3:0] events = {ev_abort, ev_resync, ev_read, ev_write};
   wire logic sw_map_write = write_strobe && address == `SPLD_MAP_DATA_OFS;

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         link_on <= `SPLD_CTRL_RESET;
         mask <= `SPLD_MASK_RESET;
         map_index <= 6'h00;
      end else if (write_strobe) begin
         case (address)
            `SPLD_CTRL_OFS: link_on <= write_data[`SPLD_CTRL_LINK_ON];
            `SPLD_MASK_OFS: mask <= write_data[3:0];
            `SPLD_MAP_INDEX_OFS: map_index <= write_data[5:0];
            default: begin
            end
         endcase
      end
   end

   // A new event in the same cycle as its clear keeps the bit set.
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         status <= 4'h0;
      end else if (write_strobe && address == `SPLD_STATUS_OFS) begin
         status <= (status & ~write_data[3:0]) | events;
      end else begin
         status <= status | events;
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         last_cmd <= 8'h00;
      end else if (state == spld_cmd && rise && bit_count == `SPLD_LAST_BIT) begin
         last_cmd <= next_cmd;
      end
   end

   // The link write has priority; a software write to the same cycle is lost,
   // because the link has no way to be held off.
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         for (int i = 0; i < `SPLD_MAP_DEPTH; i++) begin
            map[i] <= 8'h00;
         end
      end else if (link_write) begin
         map[link_addr] <= data_shift;
      end else if (sw_map_write) begin
         map[map_index] <= write_data[7:0];
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         read_data <= 32'h0;
      end else if (read_strobe) begin
         case (address)
            `SPLD_CTRL_OFS: read_data <= {31'h0, link_on};
            `SPLD_STATUS_OFS: read_data <= {28'h0, status};
            `SPLD_MASK_OFS: read_data <= {28'h0, mask};
            `SPLD_LAST_CMD_OFS: read_data <= {24'h0, last_cmd};
            `SPLD_MAP_INDEX_OFS: read_data <= {26'h0, map_index};
            `SPLD_MAP_DATA_OFS: read_data <= {24'h0, map[map_index]};
            `SPLD_LINK_STATE_OFS: read_data <= {26'h0, enabled, bit_count, state};
            default: read_data <= 32'h0;
         endcase
      end else begin
         read_data <= 32'h0;
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         irq <= 1'h0;
      end else begin
         irq <= |(status & mask);
      end
   end

endmodule : spld_device
`default_nettype wire

// *** testbench/spld_device_asserts.sv ***
/*
 Concurrent checks on the ports of the serial link device.
 Assumes a bind to spld_device, one clock domain and an asynchronous rst.
*/
`timescale 1ns/10ps
`default_nettype none
`include "spld_params.svh"
module spld_device_asserts (
   input wire logic clock,
   input wire logic rst,
   input wire logic chip_enable,
   input wire logic serial_out,
   input wire logic serial_oe_n,
   input wire logic direction_flag_n,
   input wire logic [7:0] address,
   input wire logic [31:0] write_data,
   input wire logic write_strobe,
   input wire logic read_strobe,
   input wire logic [31:0] read_data,
   input wire logic irq
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);
   // ------------------------------------------------------------------
   // Sequences
   // ------------------------------------------------------------------
   sequence s_enable_gone;
      !chip_enable [*5];
   endsequence
   sequence s_drive_start;
      $fell(serial_oe_n);
   endsequence
   a_flag_tracks_drive: assert property (direction_flag_n == serial_oe_n)
      else $error("direction flag differs from output enable");
   a_release_on_disable: assert property (s_enable_gone |-> serial_oe_n)
      else $error("line still driven after enable dropped");
   a_drive_needs_enable: assert property (!serial_oe_n |-> $past(chip_enable, 5))
      else $error("line driven without enable");
   a_quiet_after_enable: assert property ($rose(chip_enable) |-> serial_oe_n [*8])
      else $error("line driven right after enable rose");
   a_bit_held: assert property (s_drive_start |=> $stable(serial_out) [*4])
      else $error("driven bit changed too soon");
   a_read_data_idle: assert property (!$past(read_strobe) |-> read_data == 32'h0)
      else $error("read data outside its cycle");
   a_unmapped_zero: assert property (read_strobe && address == 8'h1C |=> read_data == 32'h0)
      else $error("unmapped read not zero");
   a_irq_masked: assert property (write_strobe && address == `SPLD_MASK_OFS
      && write_data[3:0] == 4'h0 |-> ##2 !irq)
      else $error("interrupt high with all masked");
endmodule : spld_device_asserts
`default_nettype wire

// *** testbench/spld_host_model.sv ***
/*
 Behavioural host of the serial link: link clock, enable and shared line.
 Assumes the device drives the line only while serial_oe_n is low.
*/
`timescale 1ns/10ps
`default_nettype none
module spld_host_model (
   output var logic link_clock,
   output var logic chip_enable,
   output wire logic line,
   input wire logic serial_out,
   input wire logic serial_oe_n
);
   // Shadow of the host's output port: line on bit 0, map enables on bits 1
   // and 2, direction flag on bit 3. The upper bits stand for unrelated
   // outputs (arbitrary levels) that every link write must carry along.
   logic [7:0] port_image = 8'hA1;
   int contention = 0;
   initial begin
      link_clock = 1'b1;
      chip_enable = 1'b0;
   end
   // Pull-up: a released line reads high, never the last driven value.
   assign line = !serial_oe_n ? serial_out : (port_image[3] ? 1'b1 : port_image[0]);
   // Enable only moves while the clock is high and the line idles high.
   task automatic set_enable(input logic v);
      port_image[1] = v;
      chip_enable = port_image[1];
   endtask : set_enable
   // Request byte: address in bits 5..0, map select in bit 6, write in bit 7.
   // The device sits on the first map and the second enable is the inverse
   // of the first, so one select bit steers both sets.
   task automatic request(input logic [7:0] req, input logic [7:0] dat,
                          output logic [7:0] rx);
      port_image[2:1] = {req[6], !req[6]};
      chip_enable = port_image[1];
      xfer({req[5:0], req[7], 1'b0}, dat, 16, rx);
   endtask : request
   // One low pulse per bit; n below 16 leaves a partial transfer.
   task automatic xfer(input logic [7:0] cmd, input logic [7:0] dat, input int n,
                       output logic [7:0] rx);
      logic b;
      rx = 8'h00;
      // Start a fraction past the system clock edge, so that no link edge and
      // no line sample ever coincides with it.
      #0.2;
      for (int i = 0; i < n; i++) begin
         b = (i < 8) ? cmd[i] : dat[(i - 8) & 7];
         link_clock = 1'b0;
         if (i >= 8 && !cmd[1]) begin
            port_image[3] = 1'b1;
            #22;
            rx[i - 8] = line;
            #2;
         end else begin
            port_image = {port_image[7:1], b};
            #24;
         end
         link_clock = 1'b1;
         #2;
         if (i < 8 && line !== b) begin
            contention++;
         end
         #22;
      end
      port_image[3] = 1'b0;
      port_image[0] = 1'b1;
   endtask : xfer
endmodule : spld_host_model
`default_nettype wire

// *** testbench/tb_serial_peripheral_link_host.sv ***
/*
 Self-checking bench of the serial link device with a host model.
 Assumes the register offsets of spld_params.svh and a 200 MHz clock.
*/
`timescale 1ns/10ps
`default_nettype none
`include "spld_params.svh"
module tb_serial_peripheral_link_host;
   logic clock = 1'b0;
   logic rst = 1'b1;
   logic [7:0] address = 8'h00;
   logic [31:0] write_data = 32'h0;
   logic write_strobe = 1'b0;
   logic read_strobe = 1'b0;
   logic serial_out, serial_oe_n, direction_flag_n, irq, link_clock, chip_enable;
   wire line;
   logic [31:0] read_data;
   logic [7:0] rx;
   int miscompares = 0;
   int check_count = 0;
   int dir_low = 0;
   always #2.5 clock = ~clock;
   // Cycles in which the device flags that it drives the line.
   always @(posedge clock) begin
      if (!direction_flag_n) begin
         dir_low++;
      end
   end
   spld_device uut (.clock(clock), .rst(rst), .link_clock(link_clock),
      .chip_enable(chip_enable), .serial_in(line), .serial_out(serial_out),
      .serial_oe_n(serial_oe_n), .direction_flag_n(direction_flag_n),
      .address(address), .write_data(write_data), .write_strobe(write_strobe),
      .read_strobe(read_strobe), .read_data(read_data), .irq(irq));
   spld_host_model host (.link_clock(link_clock), .chip_enable(chip_enable),
      .line(line), .serial_out(serial_out), .serial_oe_n(serial_oe_n));
   // ------------------------------------------------------------------
   // Tasks
   // ------------------------------------------------------------------
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      check_count++;
      if (g !== e) begin
         miscompares++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      address <= a;
      write_data <= d;
      write_strobe <= 1'b1;
      @(posedge clock);
      write_strobe <= 1'b0;
      @(posedge clock);
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      address <= a;
      read_strobe <= 1'b1;
      @(posedge clock);
      read_strobe <= 1'b0;
      @(negedge clock);
      chk(read_data, e);
      @(posedge clock);
   endtask : rd
   task automatic lw(input logic [5:0] a, input logic [7:0] d);
      int n0;
      n0 = dir_low;
      host.request({2'b10, a}, d, rx);
      repeat (6) @(posedge clock);
      chk(dir_low - n0, 32'h0);
   endtask : lw
   task automatic lr(input logic [5:0] a, input logic [7:0] e);
      int n0;
      n0 = dir_low;
      host.request({2'b00, a}, 8'h00, rx);
      repeat (6) @(posedge clock);
      chk({24'h0, rx}, {24'h0, e});
      chk({31'h0, dir_low != n0}, 32'h1);
   endtask : lr
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : give_verdict
   // ------------------------------------------------------------------
   // Tests
   // ------------------------------------------------------------------
   initial begin
      repeat (5) @(posedge clock);
      rst <= 1'b0;
      @(posedge clock);
      rd(`SPLD_CTRL_OFS, 32'h1);
      rd(`SPLD_MASK_OFS, 32'h0);
      rd(`SPLD_STATUS_OFS, 32'h0);
      rd(8'h1C, 32'h0);
      chk({30'h0, serial_oe_n, irq}, 32'h2);
      host.set_enable(1'b1);
      repeat (6) @(posedge clock);
      wr(`SPLD_MASK_OFS, 32'h1);
      lw(6'h05, 8'hA5);
      chk({31'h0, irq}, 32'h1);
      wr(`SPLD_MAP_INDEX_OFS, 32'h05);
      rd(`SPLD_MAP_DATA_OFS, 32'hA5);
      rd(`SPLD_STATUS_OFS, 32'h1);
      wr(`SPLD_STATUS_OFS, 32'hF);
      wr(`SPLD_MASK_OFS, 32'h0);
      repeat (3) @(posedge clock);
      chk({31'h0, irq}, 32'h0);
      lr(6'h05, 8'hA5);
      chk({31'h0, irq}, 32'h0);
      rd(`SPLD_STATUS_OFS, 32'h2);
      lw(6'h3F, 8'h3C);
      lr(6'h3F, 8'h3C);
      wr(`SPLD_MAP_INDEX_OFS, 32'h06);
      wr(`SPLD_MAP_DATA_OFS, 32'hC3);
      lr(6'h06, 8'hC3);
      host.request(8'hC5, 8'h00, rx);
      host.set_enable(1'b1);
      repeat (6) @(posedge clock);
      wr(`SPLD_MAP_INDEX_OFS, 32'h05);
      rd(`SPLD_MAP_DATA_OFS, 32'hA5);
      wr(`SPLD_STATUS_OFS, 32'hF);
      host.xfer({6'h04, 2'b10}, 8'hFF, 12, rx);
      host.set_enable(1'b0);
      repeat (6) @(posedge clock);
      rd(`SPLD_STATUS_OFS, 32'h8);
      wr(`SPLD_MAP_INDEX_OFS, 32'h04);
      rd(`SPLD_MAP_DATA_OFS, 32'h0);
      host.set_enable(1'b1);
      repeat (6) @(posedge clock);
      lw(6'h04, 8'h81);
      rd(`SPLD_MAP_DATA_OFS, 32'h81);
      host.xfer({6'h09, 2'b10}, 8'h00, 3, rx);
      host.xfer(8'hFF, 8'hFF, 16, rx);
      repeat (2) @(posedge clock);
      rd(`SPLD_LINK_STATE_OFS, 32'h20);
      lw(6'h02, 8'h5A);
      rd(`SPLD_LAST_CMD_OFS, 32'h0A);
      wr(`SPLD_MAP_INDEX_OFS, 32'h02);
      rd(`SPLD_MAP_DATA_OFS, 32'h5A);
      chk(host.contention, 32'h0);
      give_verdict();
   end
   initial begin
      #200000;
      miscompares++;
      give_verdict();
   end
endmodule : tb_serial_peripheral_link_host
bind spld_device spld_device_asserts chk (.clock, .rst, .chip_enable, .serial_out,
   .serial_oe_n, .direction_flag_n, .address, .write_data, .write_strobe,
   .read_strobe, .read_data, .irq);
`default_nettype wire
